// File: swdt_top.sv
// Supervision timer: AXI4-Lite registers, timed change, expiry actions
`timescale 1ns/10ps
`include "swdt_map.svh"
module swdt_top #(
    parameter int unsigned TICK_DIV = `SWDT_TICK_DIV,
    parameter int unsigned BASE_TICKS = `SWDT_BASE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic restart,
    input wire logic vector_ack,
    input wire logic always_on_fuse,
    output logic irq,
    output logic timeout_irq_req,
    output logic sys_reset_pulse
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic irq_flag;
    logic irq_en;
    logic reset_en;
    logic [3:0] timeout_sel;
    logic [2:0] win_cnt;
    logic reset_flag;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic aw_rdy;
    logic ar_rdy;

    logic reset_en_eff;
    logic irq_en_eff;
    logic window_open;
    logic do_irq;
    logic do_rst;
    logic wr_fire;
    logic wr_ok;
    logic wr_ctrl;
    logic rd_fire;
    logic rd_ok;
    logic [31:0] rd_data;
    logic [1:0] next_int_stat;
    logic f_ie;
    logic f_ce;
    logic f_re;
    logic f_flag;
    logic [3:0] f_sel;
    swdt_pkg::swdt_mode_t mode;

    swdt_cnt_if cbus ();

    swdt_counter #(
        .TICK_DIV(TICK_DIV),
        .BASE_TICKS(BASE_TICKS)
    ) u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .cbus(cbus)
    );

    // ---------------------------------------------------------------
    // Effective mode
    // ---------------------------------------------------------------
    assign reset_en_eff = always_on_fuse | reset_en | reset_flag;
    assign irq_en_eff = ~always_on_fuse & irq_en;
    assign window_open = (win_cnt != 3'h0);
    assign mode = swdt_pkg::swdt_mode_t'({reset_en_eff,
        irq_en_eff});

    // Single clock: a restart lands in the same cycle, nothing to lose
    assign cbus.clear = restart | do_rst;
    assign cbus.run = reset_en_eff | irq_en_eff;
    assign cbus.sel = timeout_sel;

    always_comb begin
        do_irq = 1'b0;
        do_rst = 1'b0;
        case (mode)
            swdt_pkg::SWDT_IRQ: begin
                do_irq = cbus.expire;
            end
            swdt_pkg::SWDT_RST: begin
                do_rst = cbus.expire;
            end
            swdt_pkg::SWDT_IRQ_RST: begin
                // Unserviced interrupt means the code is lost: reset
                do_irq = cbus.expire & ~irq_flag;
                do_rst = cbus.expire & irq_flag;
            end
            default: begin
                do_irq = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Write channel
    // ---------------------------------------------------------------
    assign wr_fire = aw_rdy & s_axi_awvalid & s_axi_wvalid;
    assign wr_ok = wr_fire & s_axi_wstrb[0];
    assign wr_ctrl = wr_ok & (s_axi_awaddr == `SWDT_OFF_CTRL);
    assign f_flag = s_axi_wdata[`SWDT_BIT_IRQ_FLAG];
    assign f_ie = s_axi_wdata[`SWDT_BIT_IRQ_EN];
    assign f_ce = s_axi_wdata[`SWDT_BIT_CHG_EN];
    assign f_re = s_axi_wdata[`SWDT_BIT_RST_EN];
    assign f_sel = {s_axi_wdata[`SWDT_BIT_SEL3],
        s_axi_wdata[`SWDT_SEL_LO_MSB:0]};

    // Both channels taken together, the cycle after both are valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= swdt_pkg::SWDT_OKAY;
        end else begin
            aw_rdy <= s_axi_awvalid & s_axi_wvalid & ~aw_rdy & ~s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (s_axi_awaddr == `SWDT_OFF_CTRL ||
                    s_axi_awaddr == `SWDT_OFF_RSTAT ||
                    s_axi_awaddr == `SWDT_OFF_INT_STAT ||
                    s_axi_awaddr == `SWDT_OFF_INT_MASK) begin
                    s_axi_bresp <= swdt_pkg::SWDT_OKAY;
                end else begin
                    s_axi_bresp <= swdt_pkg::SWDT_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = aw_rdy;
    assign s_axi_wready = aw_rdy;

    // ---------------------------------------------------------------
    // Control register and timed change window
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_flag <= 1'b0;
            irq_en <= 1'b0;
            reset_en <= 1'b0;
            timeout_sel <= `SWDT_RST_SEL;
            win_cnt <= `SWDT_RST_WIN;
        end else if (do_rst) begin
            // Own reset: control fields reinitialise except reset_en, which is set; flag keeps it armed
            irq_flag <= 1'b0;
            irq_en <= 1'b0;
            reset_en <= 1'b1;
            timeout_sel <= `SWDT_RST_SEL;
            win_cnt <= `SWDT_RST_WIN;
        end else begin
            if (window_open) begin
                win_cnt <= win_cnt - 3'h1;
            end
            if (vector_ack) begin
                irq_flag <= 1'b0;
                irq_en <= 1'b0;
            end
            if (wr_ctrl) begin
                irq_en <= f_ie & ~always_on_fuse;
                if (f_flag) begin
                    irq_flag <= 1'b0;
                end
                if (window_open && !f_ce) begin
                    reset_en <= f_re | reset_flag;
                    timeout_sel <= f_sel;
                    win_cnt <= 3'h0;
                end else if (f_ce && f_re) begin
                    reset_en <= 1'b1;
                    win_cnt <= `SWDT_WIN_CYCLES;
                end else begin
                    // Setting is always allowed, clearing is not
                    reset_en <= reset_en | f_re;
                end
            end
            if (do_irq) begin
                irq_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_flag <= 1'b0;
        end else if (do_rst) begin
            reset_flag <= 1'b1;
        end else if (wr_ok && s_axi_awaddr == `SWDT_OFF_RSTAT &&
            !s_axi_wdata[`SWDT_BIT_RST_FLAG]) begin
            reset_flag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Sticky event status, cleared by read; event set wins
    // ---------------------------------------------------------------
    assign rd_fire = ar_rdy & s_axi_arvalid;
    assign next_int_stat = (int_stat & ~{2{rd_fire &&
        s_axi_araddr == `SWDT_OFF_INT_STAT}}) | {do_rst, do_irq};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat <= 2'h0;
            int_mask <= `SWDT_RST_MASK;
        end else begin
            int_stat <= next_int_stat;
            if (wr_ok && s_axi_awaddr == `SWDT_OFF_INT_MASK) begin
                int_mask <= s_axi_wdata[1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
            timeout_irq_req <= 1'b0;
            sys_reset_pulse <= 1'b0;
        end else begin
            irq <= |(next_int_stat & int_mask);
            timeout_irq_req <= irq_flag & irq_en_eff;
            sys_reset_pulse <= do_rst;
        end
    end

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        if (s_axi_araddr == `SWDT_OFF_CTRL) begin
            rd_data[7:0] = {irq_flag, irq_en_eff, timeout_sel[3],
                window_open, reset_en_eff, timeout_sel[2:0]};
        end else if (s_axi_araddr == `SWDT_OFF_RSTAT) begin
            rd_data[0] = reset_flag;
        end else if (s_axi_araddr == `SWDT_OFF_INT_STAT) begin
            rd_data[1:0] = int_stat;
        end else if (s_axi_araddr == `SWDT_OFF_INT_MASK) begin
            rd_data[1:0] = int_mask;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= swdt_pkg::SWDT_OKAY;
        end else begin
            ar_rdy <= s_axi_arvalid & ~ar_rdy & ~s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? swdt_pkg::SWDT_OKAY :
                    swdt_pkg::SWDT_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    assign s_axi_arready = ar_rdy;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_irq_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (cbus.expire && mode == swdt_pkg::SWDT_IRQ) |=>
        irq_flag && !sys_reset_pulse)
        else $error("interrupt mode expiry wrong");
    a_reset_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (cbus.expire && mode == swdt_pkg::SWDT_RST) |=>
        sys_reset_pulse ##1 !sys_reset_pulse)
        else $error("reset mode expiry gave no one-cycle reset");
    a_combined_first: assert property (@(posedge aclk) disable iff (!aresetn)
        (cbus.expire && mode == swdt_pkg::SWDT_IRQ_RST && !irq_flag) |=>
        irq_flag && !sys_reset_pulse)
        else $error("combined mode first expiry wrong");
    a_fuse_locks: assert property (@(posedge aclk) disable iff (!aresetn)
        (always_on_fuse && wr_ctrl) |=> reset_en_eff && !irq_en)
        else $error("fuse did not lock enables");
    a_sel_guard: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && !window_open && !do_rst) |=>
        timeout_sel == $past(timeout_sel))
        else $error("select changed outside window");
    a_window_close: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(window_open) |-> ##[1:4] !window_open)
        else $error("change window stayed open");
    a_stay_armed: assert property (@(posedge aclk) disable iff (!aresetn)
        do_rst |=> reset_flag && reset_en_eff && cbus.run)
        else $error("timer disarmed after own reset");
    a_vector_ack: assert property (@(posedge aclk) disable iff (!aresetn)
        (vector_ack && !do_irq && !wr_ctrl && !do_rst) |=>
        !irq_flag && !irq_en)
        else $error("vector ack did not clear flag and enable");
endmodule

// File: swdt_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SWDT_MAP_SVH
`define SWDT_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SWDT_OFF_CTRL 8'h00
`define SWDT_OFF_RSTAT 8'h04
`define SWDT_OFF_INT_STAT 8'h08
`define SWDT_OFF_INT_MASK 8'h0C

// ---------------------------------------------------------------
// Control and reset status register fields
// ---------------------------------------------------------------
`define SWDT_BIT_IRQ_FLAG 7
`define SWDT_BIT_IRQ_EN 6
`define SWDT_BIT_SEL3 5
`define SWDT_BIT_CHG_EN 4
`define SWDT_BIT_RST_EN 3
`define SWDT_SEL_LO_MSB 2
`define SWDT_BIT_RST_FLAG 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SWDT_RST_SEL 4'h0
`define SWDT_RST_MASK 2'h0
`define SWDT_RST_WIN 3'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SWDT_CLK_HZ 100000000
`define SWDT_OSC_HZ 128000
`define SWDT_TICK_DIV (`SWDT_CLK_HZ / `SWDT_OSC_HZ)
`define SWDT_BASE_CYCLES 2048
`define SWDT_SEL_MAX 4'h9
`define SWDT_WIN_CYCLES 3'h4
`define SWDT_SHORTEST_MS 16
`define SWDT_LONGEST_S 8

`endif

// File: swdt_pkg.sv
// Types shared by the supervision timer modules
package swdt_pkg;

    // Action on expiry, Gray coded
    typedef enum logic [1:0] {
        SWDT_STOPPED = 2'h0,
        SWDT_IRQ     = 2'h1,
        SWDT_IRQ_RST = 2'h3,
        SWDT_RST     = 2'h2
    } swdt_mode_t;

    typedef enum logic [1:0] {
        SWDT_OKAY   = 2'h0,
        SWDT_SLVERR = 2'h2
    } swdt_resp_t;

endpackage

// File: swdt_cnt_if.sv
// Link between the control logic and the time-out counter
`timescale 1ns/10ps
interface swdt_cnt_if;
    logic clear;
    logic run;
    logic [3:0] sel;
    logic expire;

    modport ctl (output clear, output run, output sel, input expire);
    modport cnt (input clear, input run, input sel, output expire);
endinterface

// File: swdt_counter.sv
// Oscillator tick divider and time-out counter
`timescale 1ns/10ps
`include "swdt_map.svh"
module swdt_counter #(
    parameter int unsigned TICK_DIV = `SWDT_TICK_DIV,
    parameter int unsigned BASE_TICKS = `SWDT_BASE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    swdt_cnt_if.cnt cbus
);
    logic [15:0] div_cnt;
    logic [20:0] count;
    logic [20:0] limit;
    logic [3:0] sel_eff;
    logic tick;

    // Reserved codes behave as the longest period
    assign sel_eff = (cbus.sel > `SWDT_SEL_MAX) ? `SWDT_SEL_MAX : cbus.sel;
    assign limit = 21'(BASE_TICKS) << sel_eff;
    assign tick = (div_cnt == 16'(TICK_DIV - 1));

    // ---------------------------------------------------------------
    // Slow oscillator as an enable pulse
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || cbus.clear || !cbus.run) begin
            div_cnt <= 16'h0000;
        end else if (tick) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // Time-out counter
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 21'h000000;
            cbus.expire <= 1'b0;
        end else begin
            cbus.expire <= 1'b0;
            if (cbus.clear || !cbus.run) begin
                count <= 21'h000000;
            end else if (tick) begin
                if (count == limit - 21'h000001) begin
                    count <= 21'h000000;
                    cbus.expire <= 1'b1;
                end else begin
                    count <= count + 21'h000001;
                end
            end
        end
    end

    a_restart_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        cbus.clear |=> count == 21'h000000)
        else $error("counter not zero after restart");
    a_tick_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && cbus.run && !cbus.clear) |=> div_cnt == 16'h0000)
        else $error("divider did not wrap on tick");
    a_expire_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        cbus.expire |-> $past(count) == $past(limit) - 21'h000001)
        else $error("expiry at wrong count");
endmodule

// File: swdt_core_model.sv
// Core-side model: register bus master plus restart and vector strobes
`timescale 1ns/10ps
`include "swdt_map.svh"
module swdt_core_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    output logic [3:0] wstrb,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic restart,
    output logic vector_ack
);
    logic [1:0] last_bresp;

    initial begin
        awaddr = 8'h00;
        wstrb = 4'h0;
        bready = 1'b0;
        rready = 1'b0;
        last_bresp = 2'h0;
        awvalid = 1'b0;
        wdata = 32'h0;
        wvalid = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        restart = 1'b0;
        vector_ack = 1'b0;
    end

    // -----------------------------------------------------------
    // Bus cycles; released payload is inverted so stale data shows
    // -----------------------------------------------------------
    // Response ready rises only after the handshake, so a following
    // call never lowers and raises it in one time step
    task automatic wrs(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        awaddr <= ~a;
        wdata <= ~d;
        wstrb <= ~s;
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        last_bresp = bresp;
        bready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wrs(a, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Back-to-back writes land the second one in the third of the four open cycles
    task automatic timed(input logic [31:0] d);
        wr(`SWDT_OFF_CTRL, 32'h18);
        wr(`SWDT_OFF_CTRL, d);
    endtask

    task automatic hold(input logic v);
        restart <= v;
    endtask

    task automatic pulse_restart;
        restart <= 1'b1;
        @(posedge aclk);
        restart <= 1'b0;
    endtask

    task automatic ack;
        vector_ack <= 1'b1;
        @(posedge aclk);
        vector_ack <= 1'b0;
    endtask
endmodule

// File: swdt_top_bench.sv
// Self-checking bench for the supervision timer
`timescale 1ns/10ps
`include "swdt_map.svh"
`define CHK(g, e) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("MISMATCH at %0t got %0h exp %0h", $time, g, e); \
        end \
    end
module swdt_top_bench;
    localparam int unsigned TD = 2;
    localparam int unsigned BT = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic fuse = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] rresp, bresp;
    logic [3:0] wstrb;
    logic bready, rready;
    logic awvalid, awready, wvalid, wready, bvalid;
    logic arvalid, arready, rvalid, restart, vector_ack;
    logic irq, req, sys_rst;
    int comparisons = 0;
    int n_mismatch = 0;
    int n_rst = 0;
    int cyc = 0;

    always #5 aclk = ~aclk;

    swdt_top #(.TICK_DIV(TD), .BASE_TICKS(BT)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .restart(restart), .vector_ack(vector_ack),
        .always_on_fuse(fuse), .irq(irq), .timeout_irq_req(req),
        .sys_reset_pulse(sys_rst)
    );

    swdt_core_model core (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid),
        .wready(wready), .bvalid(bvalid), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .restart(restart),
        .wstrb(wstrb), .bresp(bresp), .bready(bready),
        .rready(rready), .vector_ack(vector_ack)
    );

    always @(posedge aclk) begin
        if (sys_rst === 1'b1) n_rst++;
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude;
        end
    end

    // -----------------------------------------------------------
    // Shared helpers
    // -----------------------------------------------------------
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        logic [1:0] er;
        er = swdt_pkg::SWDT_OKAY;
        if (a > `SWDT_OFF_INT_MASK) er = swdt_pkg::SWDT_SLVERR;
        core.rd(a, d, r);
        `CHK(d, e);
        `CHK(r, er);
    endtask

    // Waits for the chosen action; n counts edges from the restart
    task automatic expiry(input logic rst, input logic rs, input int e);
        int n;
        n = 0;
        if (rs) core.pulse_restart;
        do begin
            @(posedge aclk);
            n++;
        end while ((rst ? sys_rst : req) !== 1'b1 && n < 4000);
        `CHK(n >= e - 1 && n <= e + 5, 1'b1);
    endtask

    task automatic quiet;
        core.hold(1'b1);
        core.wr(`SWDT_OFF_RSTAT, 32'h0);
        core.timed(32'h0);
        core.hold(1'b0);
        @(posedge aclk);
    endtask

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    task automatic t_regs;
        rchk(`SWDT_OFF_CTRL, 32'h0);
        rchk(`SWDT_OFF_RSTAT, 32'h0);
        rchk(`SWDT_OFF_INT_MASK, 32'h0);
        rchk(8'h10, 32'h0);
        // Low byte strobe off: the write must not arm the timer
        core.wrs(`SWDT_OFF_CTRL, 32'h08, 4'hE);
        `CHK(core.last_bresp, swdt_pkg::SWDT_OKAY);
        rchk(`SWDT_OFF_CTRL, 32'h0);
        core.wr(8'h10, 32'h0);
        `CHK(core.last_bresp, swdt_pkg::SWDT_SLVERR);
        core.wr(`SWDT_OFF_CTRL, 32'h05);
        `CHK(core.last_bresp, swdt_pkg::SWDT_OKAY);
        rchk(`SWDT_OFF_CTRL, 32'h0);
        core.timed(32'h05);
        rchk(`SWDT_OFF_CTRL, 32'h05);
        core.wr(`SWDT_OFF_CTRL, 32'h18);
        repeat (8) @(posedge aclk);
        core.wr(`SWDT_OFF_CTRL, 32'h0);
        rchk(`SWDT_OFF_CTRL, 32'h0D);
        core.timed(32'h0);
        rchk(`SWDT_OFF_CTRL, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_irq;
        int n0;
        n0 = n_rst;
        core.wr(`SWDT_OFF_INT_MASK, 32'h1);
        core.timed(32'h01);
        core.wr(`SWDT_OFF_CTRL, 32'h41);
        repeat (6) begin
            core.pulse_restart;
            repeat (9) @(posedge aclk);
        end
        `CHK(req, 1'b0);
        expiry(1'b0, 1'b1, TD * (BT << 1));
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1);
        core.hold(1'b1);
        rchk(`SWDT_OFF_INT_STAT, 32'h1);
        rchk(`SWDT_OFF_INT_STAT, 32'h0);
        `CHK(irq, 1'b0);
        core.ack;
        rchk(`SWDT_OFF_CTRL, 32'h01);
        `CHK(req, 1'b0);
        core.wr(`SWDT_OFF_INT_MASK, 32'h0);
        core.wr(`SWDT_OFF_CTRL, 32'h41);
        expiry(1'b0, 1'b1, TD * (BT << 1));
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0);
        core.ack;
        rchk(`SWDT_OFF_INT_STAT, 32'h1);
        `CHK(n_rst, n0);
        $display("test irq done");
    endtask

    task automatic t_reset;
        // Select code 1 is still in force from the interrupt test
        core.wr(`SWDT_OFF_CTRL, 32'h08);
        rchk(`SWDT_OFF_CTRL, 32'h09);
        expiry(1'b1, 1'b1, TD * (BT << 1));
        @(posedge aclk);
        `CHK(sys_rst, 1'b0);
        expiry(1'b1, 1'b1, TD * BT);
        core.hold(1'b1);
        rchk(`SWDT_OFF_RSTAT, 32'h1);
        rchk(`SWDT_OFF_INT_STAT, 32'h2);
        core.timed(32'h0);
        rchk(`SWDT_OFF_CTRL, 32'h08);
        quiet;
        rchk(`SWDT_OFF_CTRL, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_comb;
        int n0;
        n0 = n_rst;
        core.wr(`SWDT_OFF_CTRL, 32'h48);
        expiry(1'b0, 1'b1, TD * BT);
        core.hold(1'b1);
        `CHK(n_rst, n0);
        rchk(`SWDT_OFF_CTRL, 32'hC8);
        core.wr(`SWDT_OFF_CTRL, 32'hC8);
        rchk(`SWDT_OFF_CTRL, 32'h48);
        expiry(1'b0, 1'b1, TD * BT);
        expiry(1'b1, 1'b0, TD * BT);
        quiet;
        $display("test combined done");
    endtask

    task automatic t_fuse;
        fuse <= 1'b1;
        core.hold(1'b1);
        @(posedge aclk);
        rchk(`SWDT_OFF_CTRL, 32'h08);
        core.wr(`SWDT_OFF_CTRL, 32'h40);
        rchk(`SWDT_OFF_CTRL, 32'h08);
        expiry(1'b1, 1'b1, TD * BT);
        fuse <= 1'b0;
        quiet;
        $display("test fuse done");
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_irq;
        t_reset;
        t_comb;
        t_fuse;
        conclude;
    end
endmodule
